/* data_space_access.sv */
// Data-space access unit: byte/word paths, alignment trap, working registers
//
// Notes on behaviour
// (R1) Post-increment steps one byte or two bytes
// (R2) Byte read fetches word, lsb selects byte
// (R3) Selected byte lands on the low lane
// (R4) Two byte lanes, shared decode, separate strobes
// (R5) Requester keeps word accesses at even addresses
// (R6) Odd word access raises address error trap
// (R7) Misaligned read completes in the same cycle as the trap
// (R8) Misaligned write executes but stores nothing
// (R9) Trap sees state from before the fault
// (R10) Byte load changes register low byte only
// (R11) Sign extend copies bit 7 upward
// (R12) Zero extend clears register high byte
// (R13) Some operations accept word size only
// (R14) Near region reachable by 13-bit address
// (R15) Beyond near region: indirect or move only
// (R16) Move reaches whole space by 16-bit address
// (R17) Low 2 Kbytes hold special function registers
// (R18) Unimplemented special register addresses read zero
// (R19) Special region decoded in 32-byte blocks
// (R20) Alignment check ignores byte-sized accesses
`timescale 1ns/10ps
`default_nettype none
module data_space_access
    import ds_pkg::*;
#(
    parameter int WORDS = RAM_WORDS
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic req_i,
    input wire op_kind_t op_i,
    input wire addr_mode_t mode_i,
    input wire logic byte_op_i,
    input wire logic word_only_op_i,
    input wire logic move_op_i,
    input wire logic [15:0] direct_addr_i,
    input wire logic [3:0] source_work_reg_i,
    input wire logic [3:0] dest_work_reg_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] special_function_reg_rdata_i,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic [15:0] effective_addr_o,
    output logic addr_error_trap_o,
    output logic illegal_op_o,
    output logic special_function_reg_write_o,
    output logic [15:0] special_function_reg_addr_o,
    output logic [15:0] special_function_reg_wdata_o,
    output logic [1:0] special_function_reg_lane_we_o
);
    if (WORDS < 1 || WORDS > RAM_WORDS) begin : g_bad_words
        $error("data_space_access: bad WORDS");
    end

    // ----------------------------------------------------------------
    // Effective address
    // ----------------------------------------------------------------
    logic [15:0] wreg [WREG_CNT];
    logic [15:0] effective_addr;
    logic [15:0] next_wreg_src;
    logic misaligned;
    logic addr_ok;
    logic mem_op;

    assign mem_op = (op_i == OP_READ) || (op_i == OP_WRITE) || (op_i == OP_LOAD);

    always_comb begin
        addr_ok = 1'b1;
        if (mode_i == MODE_DIRECT) begin
            if (move_op_i) begin
                effective_addr = direct_addr_i; // [R16]
            end else begin
                effective_addr = {3'h0, direct_addr_i[NEAR_W-1:0]}; // [R14]
                addr_ok = (direct_addr_i <= NEAR_LAST); // [R15]
            end
        end else begin
            effective_addr = wreg[source_work_reg_i];
        end
    end

    // Word access only checks the lsb; byte access never traps
    assign misaligned = !byte_op_i && effective_addr[0] && mem_op; // [R6] [R20]

    always_comb begin
        next_wreg_src = wreg[source_work_reg_i];
        if (mode_i == MODE_POST_INC) begin
            next_wreg_src = wreg[source_work_reg_i] + (byte_op_i ? STEP_BYTE : STEP_WORD); // [R1]
        end
    end

    // ----------------------------------------------------------------
    // Region decode and byte lanes
    // ----------------------------------------------------------------
    logic in_special;
    logic special_impl;
    logic [15:0] ram_word;
    logic [15:0] word_rd;
    logic [1:0] lane_we;
    logic [15:0] lane_wdata;
    logic do_write;
    logic illegal;

    special_block_decode u_dec (
        .addr_i(effective_addr),
        .in_special_o(in_special),
        .implemented_o(special_impl)
    );

    assign illegal = (byte_op_i && word_only_op_i) || !addr_ok; // [R13]
    // A faulting write runs as a no-op on memory so the trap sees old data
    assign do_write = req_i && (op_i == OP_WRITE) && !misaligned && !illegal; // [R8] [R9]

    always_comb begin
        lane_we = 2'b00;
        lane_wdata = wdata_i;
        if (do_write) begin
            if (byte_op_i) begin
                lane_we = effective_addr[0] ? 2'b10 : 2'b01; // [R4]
                lane_wdata = {wdata_i[7:0], wdata_i[7:0]};
            end else begin
                lane_we = 2'b11;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            byte_lane_ram #(.WORDS(WORDS), .AW(NEAR_W)) u_lane (
                .clk_sys_i(clk_sys_i),
                .word_addr_i(effective_addr[NEAR_W:1]),
                .write_i(lane_we[g] && !in_special),
                .wdata_i(lane_wdata[8*g +: 8]),
                .rdata_o(ram_word[8*g +: 8])
            );
        end
    endgenerate

    always_comb begin
        if (in_special) begin
            word_rd = special_impl ? special_function_reg_rdata_i : ZERO_WORD; // [R17] [R18] [R19]
        end else begin
            word_rd = ram_word; // [R2]
        end
    end

    logic [15:0] read_val;
    always_comb begin
        if (byte_op_i) begin
            read_val = {8'h00, effective_addr[0] ? word_rd[15:8] : word_rd[7:0]}; // [R2] [R3]
        end else begin
            read_val = word_rd;
        end
    end

    // ----------------------------------------------------------------
    // Working registers
    // ----------------------------------------------------------------
    logic [15:0] dst_val;
    assign dst_val = wreg[dest_work_reg_i];

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < WREG_CNT; i++) begin
                wreg[i] <= ZERO_WORD;
            end
        end else if (req_i && !illegal) begin
            if (mode_i == MODE_POST_INC && mem_op) begin
                wreg[source_work_reg_i] <= next_wreg_src;
            end
            unique case (op_i)
                OP_LOAD: begin
                    // A misaligned read still completes
                    if (byte_op_i) begin
                        wreg[dest_work_reg_i] <= {dst_val[15:8], read_val[7:0]}; // [R10] [R7]
                    end else begin
                        wreg[dest_work_reg_i] <= read_val; // [R7]
                    end
                end
                OP_SIGN_EXT: begin
                    wreg[dest_work_reg_i] <= {{8{dst_val[7]}}, dst_val[7:0]}; // [R11]
                end
                OP_ZERO_EXT: begin
                    wreg[dest_work_reg_i] <= {8'h00, dst_val[7:0]}; // [R12]
                end
                OP_READ, OP_WRITE, OP_NOP: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            done_o <= 1'b0;
            rdata_o <= ZERO_WORD;
            effective_addr_o <= ZERO_WORD;
            illegal_op_o <= 1'b0;
        end else begin
            done_o <= req_i;
            illegal_op_o <= req_i && illegal;
            if (req_i) begin
                rdata_o <= read_val;
                effective_addr_o <= effective_addr;
            end
        end
    end

    // Trap registered in the same cycle as done_o, one cycle after the faulting request
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            addr_error_trap_o <= 1'b0;
        end else begin
            addr_error_trap_o <= req_i && misaligned && !illegal; // [R6] [R7] [R9]
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            special_function_reg_write_o <= 1'b0;
            special_function_reg_addr_o <= ZERO_WORD;
            special_function_reg_wdata_o <= ZERO_WORD;
            special_function_reg_lane_we_o <= 2'b00;
        end else begin
            special_function_reg_write_o <= |lane_we && in_special;
            special_function_reg_lane_we_o <= in_special ? lane_we : 2'b00; // [R4]
            special_function_reg_addr_o <= effective_addr;
            special_function_reg_wdata_o <= lane_wdata;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_trap_on_odd: assert property ( // [R6]
        req_i && op_i == OP_READ && !byte_op_i && effective_addr[0] && !illegal
        |=> addr_error_trap_o)
        else $error("odd word read did not trap");
    a_no_byte_trap: assert property ( // [R20]
        req_i && byte_op_i |=> !addr_error_trap_o)
        else $error("byte access trapped");
    a_bad_write_held: assert property ( // [R8]
        misaligned && op_i == OP_WRITE |-> lane_we == 2'b00)
        else $error("misaligned write reached memory");
    a_byte_lane_one: assert property ( // [R4]
        do_write && byte_op_i |-> $onehot(lane_we) && lane_we[effective_addr[0]])
        else $error("byte write strobed wrong lane");
    a_byte_low_lane: assert property ( // [R3]
        req_i && byte_op_i |=> rdata_o[15:8] == 8'h00)
        else $error("byte read not on low lane");
    a_special_gap_zero: assert property ( // [R18]
        req_i && in_special && !special_impl && !byte_op_i |=> rdata_o == ZERO_WORD)
        else $error("unimplemented block read nonzero");
    a_post_inc_step: assert property ( // [R1]
        req_i && mode_i == MODE_POST_INC && mem_op && !illegal
        && source_work_reg_i != dest_work_reg_i
        |=> wreg[$past(source_work_reg_i)] - $past(effective_addr)
            == ($past(byte_op_i) ? STEP_BYTE : STEP_WORD))
        else $error("post increment step wrong");
    a_sign_ext: assert property ( // [R11]
        req_i && op_i == OP_SIGN_EXT && !illegal
        |=> wreg[$past(dest_work_reg_i)][15:8] == {8{$past(dst_val[7])}})
        else $error("sign extend wrong");
    a_byte_load_hi: assert property ( // [R10]
        req_i && op_i == OP_LOAD && byte_op_i && !illegal
        && source_work_reg_i != dest_work_reg_i
        |=> wreg[$past(dest_work_reg_i)][15:8] == $past(dst_val[15:8]))
        else $error("byte load disturbed high byte");

    a_zero_ext_hi: assert property ( // [R12]
        req_i && op_i == OP_ZERO_EXT && !illegal |=> wreg[$past(dest_work_reg_i)][15:8] == 8'h00)
        else $error("zero extend left high byte");
    a_word_both_lanes: assert property ( // [R4]
        do_write && !byte_op_i |-> lane_we == 2'b11)
        else $error("word write missed a lane");
    a_near_window: assert property ( // [R14]
        req_i && mode_i == MODE_DIRECT && !move_op_i && !illegal |-> effective_addr <= NEAR_LAST)
        else $error("direct address left near region");
    a_move_reach: assert property ( // [R16]
        req_i && mode_i == MODE_DIRECT && move_op_i |-> effective_addr == direct_addr_i)
        else $error("move direct address cut short");
    a_far_direct_refused: assert property ( // [R15]
        req_i && mode_i == MODE_DIRECT && !move_op_i && direct_addr_i > NEAR_LAST |=> illegal_op_o)
        else $error("far direct access not refused");
    a_word_only_refused: assert property ( // [R13]
        req_i && byte_op_i && word_only_op_i |=> illegal_op_o && !addr_error_trap_o)
        else $error("byte form of word-only op accepted");
    a_trap_on_write: assert property ( // [R6]
        req_i && op_i == OP_WRITE && !byte_op_i && effective_addr[0] && !illegal |=> addr_error_trap_o)
        else $error("odd word write did not trap");
    a_special_strobe: assert property ( // [R17]
        req_i && op_i == OP_WRITE && in_special && !misaligned && !illegal
        |=> special_function_reg_write_o)
        else $error("special register write not strobed");

    c_byte_write: cover property (do_write && byte_op_i);
    c_trap_read: cover property (req_i && misaligned && op_i == OP_READ);
    c_trap_write: cover property (req_i && misaligned && op_i == OP_WRITE);
    c_special_gap: cover property (req_i && in_special && !special_impl);
    c_sign_ext: cover property (req_i && op_i == OP_SIGN_EXT && !illegal);
endmodule
`default_nettype wire

/* ds_pkg.sv */
// Package: data-space map, access sizes and decode constants
package ds_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int NEAR_W = 13;
    localparam logic [15:0] NEAR_LAST = 16'h1fff;
    localparam logic [15:0] SPECIAL_LAST = 16'h07ff;
    localparam int SPECIAL_BLK_SHIFT = 5;
    localparam int SPECIAL_BLK_CNT = 64;
    // One bit per 32-byte block, block 0 in bit 0
    localparam logic [63:0] SPECIAL_BLK_MAP = 64'h0cf7_0000_037f_ffff;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam int RAM_WORDS = 8192;
    localparam int WREG_CNT = 16;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    typedef enum logic [1:0] {
        MODE_DIRECT,
        MODE_INDIRECT,
        MODE_POST_INC
    } addr_mode_t;

    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_LOAD,
        OP_SIGN_EXT,
        OP_ZERO_EXT,
        OP_NOP
    } op_kind_t;
endpackage

/* byte_lane_ram.sv */
// One byte-wide lane of data memory with its own write strobe
`timescale 1ns/10ps
`default_nettype none
module byte_lane_ram #(
    parameter int WORDS = 8192,
    parameter int AW = 13
) (
    input wire logic clk_sys_i,
    input wire logic [AW-1:0] word_addr_i,
    input wire logic write_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    if (WORDS < 1 || WORDS > (1 << AW)) begin : g_bad_words
        $error("byte_lane_ram: WORDS exceeds address range");
    end

    logic [7:0] mem [WORDS];

    always_ff @(posedge clk_sys_i) begin
        if (write_i) begin
            mem[word_addr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[word_addr_i];
endmodule
`default_nettype wire

/* sfr_block_decode.sv */
// Decode of the special function register region in 32-byte blocks
`timescale 1ns/10ps
`default_nettype none
module special_block_decode
    import ds_pkg::*;
(
    input wire logic [15:0] addr_i,
    output logic in_special_o,
    output logic implemented_o
);
    localparam int BLK_W = $clog2(SPECIAL_BLK_CNT);

    // The block map must tile the region exactly, or gaps would alias
    if ((SPECIAL_BLK_CNT << SPECIAL_BLK_SHIFT) != int'(SPECIAL_LAST) + 1) begin : g_bad_map
        $error("special_block_decode: block map does not cover region");
    end

    logic [BLK_W-1:0] blk;

    assign blk = addr_i[SPECIAL_BLK_SHIFT +: BLK_W];
    assign in_special_o = (addr_i <= SPECIAL_LAST);
    assign implemented_o = in_special_o && SPECIAL_BLK_MAP[blk];
endmodule
`default_nettype wire

/* sfr_bank_model.sv */
// Behavioural model of the external special-function-register bank
`timescale 1ns/10ps
`default_nettype none
module special_bank_model (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic write_i,
    input wire logic [1:0] lane_we_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);
    // One shared store answers every address, nonzero from reset, so the
    // access unit alone must blank unimplemented blocks
    logic [15:0] store;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            store <= 16'hc3a5;
        end else if (write_i) begin
            if (lane_we_i[0]) begin
                store[7:0] <= wdata_i[7:0];
            end
            if (lane_we_i[1]) begin
                store[15:8] <= wdata_i[15:8];
            end
        end
    end

    assign rdata_o = store;
endmodule
`default_nettype wire

/* data_space_access_tb.sv */
// Self-checking testbench for the data-space access unit
`timescale 1ns/10ps
`default_nettype none
module data_space_access_tb;
    import ds_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i, req, byte_s, wo_s, move_s, done_o, trap_o, ill_o, spec_write;
    op_kind_t op_s;
    addr_mode_t mode_s;
    logic [15:0] daddr, wdata, spec_rdata, rdata_o, eff_addr, spec_addr, spec_wdata;
    logic [3:0] src_r, dst_r;
    logic [1:0] lane_o;
    int failures = 0;
    int checks_done = 0;

    always #50 clk_sys_i = ~clk_sys_i;

    data_space_access dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req),
        .op_i(op_s), .mode_i(mode_s), .byte_op_i(byte_s), .word_only_op_i(wo_s),
        .move_op_i(move_s), .direct_addr_i(daddr), .source_work_reg_i(src_r),
        .dest_work_reg_i(dst_r), .wdata_i(wdata), .special_function_reg_rdata_i(spec_rdata),
        .done_o(done_o), .rdata_o(rdata_o), .effective_addr_o(eff_addr),
        .addr_error_trap_o(trap_o), .illegal_op_o(ill_o),
        .special_function_reg_write_o(spec_write), .special_function_reg_addr_o(spec_addr),
        .special_function_reg_wdata_o(spec_wdata), .special_function_reg_lane_we_o(lane_o));

    special_bank_model partner_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .write_i(spec_write), .lane_we_i(lane_o), .wdata_i(spec_wdata),
        .rdata_o(spec_rdata));

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One request held for one edge; outputs judged after the answering edge
    task automatic access(input op_kind_t op, input addr_mode_t md, input logic bo,
        input logic wo, input logic mv, input logic [15:0] ad, input logic [3:0] src,
        input logic [3:0] dst, input logic [15:0] wd);
        @(posedge clk_sys_i);
        #1;
        req = 1'b1;
        op_s = op;
        mode_s = md;
        byte_s = bo;
        wo_s = wo;
        move_s = mv;
        daddr = ad;
        src_r = src;
        dst_r = dst;
        wdata = wd;
        @(posedge clk_sys_i);
        #1;
        req = 1'b0;
        check({15'h0, done_o}, 16'h0001);
    endtask

    // Word accesses stay even unless a scenario asks for the fault
    task automatic wr(input logic [15:0] ad, input logic [15:0] wd, input logic bo);
        access(OP_WRITE, MODE_DIRECT, bo, 1'b0, ad > NEAR_LAST, ad, 4'h0, 4'h0, wd);
    endtask

    task automatic rd(input logic [15:0] ad, input logic bo);
        access(OP_READ, MODE_DIRECT, bo, 1'b0, ad > NEAR_LAST, ad, 4'h0, 4'h0, 16'h0);
    endtask

    task automatic peek(input logic [3:0] r, input logic [15:0] exp);
        access(OP_READ, MODE_INDIRECT, 1'b1, 1'b0, 1'b0, 16'h0, r, 4'h0, 16'h0);
        check(eff_addr, exp);
    endtask

    task automatic t_lanes();
        wr(16'h0800, 16'h1234, 1'b0);
        check({15'h0, spec_write}, 16'h0000);
        wr(16'h0801, 16'h005a, 1'b1);
        rd(16'h0800, 1'b0);
        check(rdata_o, 16'h5a34);
        rd(16'h0801, 1'b1);
        check(rdata_o, 16'h005a);
        check({15'h0, trap_o}, 16'h0000);
        rd(16'h0800, 1'b1);
        check(rdata_o, 16'h0034);
        $display("t_lanes finished");
    endtask

    task automatic t_misalign();
        wr(16'h0802, 16'h1111, 1'b0);
        wr(16'h0803, 16'hbeef, 1'b0);
        check({15'h0, trap_o}, 16'h0001);
        rd(16'h0802, 1'b0);
        check(rdata_o, 16'h1111);
        rd(16'h0801, 1'b0);
        check({15'h0, trap_o}, 16'h0001);
        check(rdata_o, 16'h5a34);
        $display("t_misalign finished");
    endtask

    task automatic t_postinc();
        wr(16'h0806, 16'h0810, 1'b0);
        access(OP_LOAD, MODE_DIRECT, 1'b0, 1'b0, 1'b0, 16'h0806, 4'h0, 4'h1, 16'h0);
        access(OP_READ, MODE_POST_INC, 1'b1, 1'b0, 1'b0, 16'h0, 4'h1, 4'h0, 16'h0);
        check(eff_addr, 16'h0810);
        access(OP_READ, MODE_POST_INC, 1'b1, 1'b0, 1'b0, 16'h0, 4'h1, 4'h0, 16'h0);
        check(eff_addr, 16'h0811);
        peek(4'h1, 16'h0812);
        access(OP_READ, MODE_POST_INC, 1'b0, 1'b0, 1'b0, 16'h0, 4'h1, 4'h0, 16'h0);
        peek(4'h1, 16'h0814);
        $display("t_postinc finished");
    endtask

    task automatic t_extend();
        wr(16'h0808, 16'ha5c3, 1'b0);
        wr(16'h080a, 16'h1280, 1'b0);
        access(OP_LOAD, MODE_DIRECT, 1'b0, 1'b0, 1'b0, 16'h080a, 4'h0, 4'h2, 16'h0);
        access(OP_LOAD, MODE_DIRECT, 1'b1, 1'b0, 1'b0, 16'h0808, 4'h0, 4'h2, 16'h0);
        peek(4'h2, 16'h12c3);
        access(OP_SIGN_EXT, MODE_DIRECT, 1'b0, 1'b0, 1'b0, 16'h0, 4'h0, 4'h2, 16'h0);
        peek(4'h2, 16'hffc3);
        access(OP_ZERO_EXT, MODE_DIRECT, 1'b0, 1'b0, 1'b0, 16'h0, 4'h0, 4'h2, 16'h0);
        peek(4'h2, 16'h00c3);
        $display("t_extend finished");
    endtask

    task automatic t_reach();
        access(OP_READ, MODE_DIRECT, 1'b1, 1'b1, 1'b0, 16'h0800, 4'h0, 4'h0, 16'h0);
        check({15'h0, ill_o}, 16'h0001);
        access(OP_READ, MODE_DIRECT, 1'b0, 1'b1, 1'b0, 16'h0800, 4'h0, 4'h0, 16'h0);
        check({15'h0, ill_o}, 16'h0000);
        wr(16'h1ffe, 16'h6666, 1'b0);
        check({15'h0, ill_o}, 16'h0000);
        wr(16'h2000, 16'h5555, 1'b0);
        check({15'h0, ill_o}, 16'h0000);
        access(OP_WRITE, MODE_DIRECT, 1'b0, 1'b0, 1'b0, 16'h2000, 4'h0, 4'h0, 16'h4444);
        check({15'h0, ill_o}, 16'h0001);
        rd(16'h2000, 1'b0);
        check(rdata_o, 16'h5555);
        $display("t_reach finished");
    endtask

    task automatic t_special();
        wr(16'h0080, 16'h1234, 1'b0);
        check({15'h0, spec_write}, 16'h0001);
        check(spec_addr, 16'h0080);
        check({14'h0, lane_o}, 16'h0003);
        wr(16'h0083, 16'h0077, 1'b1);
        check({14'h0, lane_o}, 16'h0002);
        check(spec_wdata, 16'h7777);
        rd(16'h0082, 1'b0);
        check(rdata_o, 16'h7734);
        rd(16'h0400, 1'b0);
        check(rdata_o, 16'h0000);
        $display("t_special finished");
    endtask

    initial begin
        #(5000 * 100);
        failures++;
        tally_and_finish();
    end

    initial begin
        {resetn_i, req, byte_s, wo_s, move_s} = 5'h00;
        op_s = OP_NOP;
        mode_s = MODE_DIRECT;
        {daddr, wdata, src_r, dst_r} = 40'h0;
        repeat (16) @(posedge clk_sys_i);
        #1;
        resetn_i = 1'b1;
        check(rdata_o, 16'h0000);
        t_lanes();
        t_misalign();
        t_postinc();
        t_extend();
        t_reach();
        t_special();
        tally_and_finish();
    end
endmodule
`default_nettype wire
